// file: core/acrb_regbank.sv
// Gain-control register bank: left applied-gain readback and right channel
// configuration, reached as an AXI4-Lite slave.
// Assumes one clock, synchronous active-low reset, and a gain datapath that
// presents its requested gains every cycle.
//
// How it works
// - Left applied gain reads as signed half-dB, -12 dB up to +58 dB.
// - Left gain readback ignores writes and reads zero after reset.
// - Control byte one bit 7 enables gain control; cleared at reset.
// - Bits 6..4 pick one of eight target levels, -5.5 to -24 dBFS.
// - Bits 1..0 pick gain hysteresis: off, 0.5, 1.0 or 1.5 dB.
// - Control byte two bits 7..6 pick hysteresis 1, 2, 4 dB or off.
// - Bits 5..1 set noise threshold from -30 dB; zero disables gate.
// - Seven-bit maximum gain, half-dB steps, saturates at 58 dB, resets ones.
`timescale 1ns/10ps
module acrb_regbank
    import acrb_pkg::*;
(
    input  logic              aclk,
    input  logic              aresetn,
    input  logic [ADDR_W-1:0] s_axi_awaddr,
    input  logic              s_axi_awvalid,
    output logic              s_axi_awready,
    input  logic [DATA_W-1:0] s_axi_wdata,
    input  logic [3:0]        s_axi_wstrb,
    input  logic              s_axi_wvalid,
    output logic              s_axi_wready,
    output logic [1:0]        s_axi_bresp,
    output logic              s_axi_bvalid,
    input  logic              s_axi_bready,
    input  logic [ADDR_W-1:0] s_axi_araddr,
    input  logic              s_axi_arvalid,
    output logic              s_axi_arready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0]        s_axi_rresp,
    output logic              s_axi_rvalid,
    input  logic              s_axi_rready,
    input  logic [7:0]        left_gain_in,
    input  logic [7:0]        right_gain_req,
    output acrb_cfg_t         right_cfg,
    output logic [7:0]        right_gain_applied,
    output logic              right_noise_gate_on
);

    logic              awready_q;
    logic              aw_hold_q;
    logic              aw_hold_d;
    logic [ADDR_W-1:0] aw_addr_q;
    logic              wready_q;
    logic              w_hold_q;
    logic              w_hold_d;
    logic [7:0]        w_byte_q;
    logic              w_lane_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              b_done;
    logic              wr_go;
    logic              wr_byte;
    logic              arready_q;
    logic              rvalid_q;
    logic [DATA_W-1:0] rdata_q;
    logic [1:0]        rresp_q;
    logic              ar_take;
    acrb_cfg_t         cfg_q;
    logic [7:0]        left_gain_q;
    logic [7:0]        left_clamped;
    logic [7:0]        right_hi;
    logic [7:0]        right_clamped;
    logic [7:0]        right_gain_q;
    logic              noise_on_q;

    assign s_axi_awready       = awready_q;
    assign s_axi_wready        = wready_q;
    assign s_axi_bvalid        = bvalid_q;
    assign s_axi_bresp         = bresp_q;
    assign s_axi_arready       = arready_q;
    assign s_axi_rvalid        = rvalid_q;
    assign s_axi_rdata         = rdata_q;
    assign s_axi_rresp         = rresp_q;
    assign right_cfg           = cfg_q;
    assign right_gain_applied  = right_gain_q;
    assign right_noise_gate_on = noise_on_q;

    // Address and data taken in either order, held until the response is taken
    assign b_done  = bvalid_q && s_axi_bready;
    assign wr_go   = aw_hold_q && w_hold_q && !bvalid_q;
    assign wr_byte = wr_go && w_lane_q;
    assign ar_take = s_axi_arvalid && arready_q;

    always_comb begin
        aw_hold_d = aw_hold_q;
        if (s_axi_awvalid && awready_q) begin
            aw_hold_d = 1'b1;
        end else if (b_done) begin
            aw_hold_d = 1'b0;
        end
    end

    always_comb begin
        w_hold_d = w_hold_q;
        if (s_axi_wvalid && wready_q) begin
            w_hold_d = 1'b1;
        end else if (b_done) begin
            w_hold_d = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            awready_q <= 1'b0;
            aw_addr_q <= '0;
        end else begin
            aw_hold_q <= aw_hold_d;
            awready_q <= !aw_hold_d;
            if (s_axi_awvalid && awready_q) begin
                aw_addr_q <= s_axi_awaddr;
            end
        end
    end

    // Only the low byte lane carries register data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_hold_q <= 1'b0;
            wready_q <= 1'b0;
            w_byte_q <= 8'h00;
            w_lane_q <= 1'b0;
        end else begin
            w_hold_q <= w_hold_d;
            wready_q <= !w_hold_d;
            if (s_axi_wvalid && wready_q) begin
                w_byte_q <= s_axi_wdata[7:0];
                w_lane_q <= s_axi_wstrb[0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q  <= acrb_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
        end else if (b_done) begin
            bvalid_q <= 1'b0;
        end
    end

    // Reserved bits are never stored, so they read zero whatever is written
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_q <= CFG_RESET;
        end else if (wr_byte) begin
            if (acrb_hit(aw_addr_q, IDX_EN_TGT)) begin
                cfg_q.enable    <= w_byte_q[EN_BIT];
                cfg_q.target    <= w_byte_q[TGT_LSB +: 3];
                cfg_q.gain_hyst <= w_byte_q[GHYST_LSB +: 2];
            end
            if (acrb_hit(aw_addr_q, IDX_HYST_NOISE)) begin
                cfg_q.level_hyst <= w_byte_q[LHYST_LSB +: 2];
                cfg_q.noise_thr  <= w_byte_q[NOISE_LSB +: 5];
            end
            if (acrb_hit(aw_addr_q, IDX_MAX_GAIN)) begin
                cfg_q.max_gain <= w_byte_q[MAXG_LSB +: 7];
            end
        end
    end

    function automatic logic [7:0] rd_byte(input logic [ADDR_W-1:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (acrb_hit(a, IDX_LEFT_GAIN)) begin
            v = left_gain_q;
        end else if (acrb_hit(a, IDX_EN_TGT)) begin
            v[EN_BIT]            = cfg_q.enable;
            v[TGT_LSB +: 3]      = cfg_q.target;
            v[GHYST_LSB +: 2]    = cfg_q.gain_hyst;
        end else if (acrb_hit(a, IDX_HYST_NOISE)) begin
            v[LHYST_LSB +: 2]    = cfg_q.level_hyst;
            v[NOISE_LSB +: 5]    = cfg_q.noise_thr;
        end else if (acrb_hit(a, IDX_MAX_GAIN)) begin
            v[MAXG_LSB +: 7]     = cfg_q.max_gain;
        end
        return v;
    endfunction

    // Answer one cycle after the address is taken; unmapped reads give zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= '0;
            rresp_q   <= RESP_OKAY;
        end else if (ar_take) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= {24'h000000, rd_byte(s_axi_araddr)};
            rresp_q   <= acrb_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
        end else if (!rvalid_q) begin
            arready_q <= 1'b1;
        end
    end

    // Readback follows the datapath only, never the bus
    acrb_gain_limit u_left_limit (
        .req  (left_gain_in),
        .lo   (GAIN_MIN),
        .hi   (GAIN_MAX),
        .gain (left_clamped)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            left_gain_q <= RST_LEFT_GAIN;
        end else begin
            left_gain_q <= left_clamped;
        end
    end

    // Ceiling drops to the programmed maximum only while enabled
    assign right_hi = cfg_q.enable ? {1'b0, acrb_max_eff(cfg_q.max_gain)} : GAIN_MAX;

    acrb_gain_limit u_right_limit (
        .req  (right_gain_req),
        .lo   (GAIN_MIN),
        .hi   (right_hi),
        .gain (right_clamped)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            right_gain_q <= 8'h00;
        end else begin
            right_gain_q <= right_clamped;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            noise_on_q <= 1'b0;
        end else begin
            noise_on_q <= cfg_q.enable && (cfg_q.noise_thr != 5'h00);
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_gain_span;
        ($signed(left_gain_q) >= $signed(GAIN_MIN)) && ($signed(left_gain_q) <= $signed(GAIN_MAX));
    endproperty
    a_gain_span: assert property (p_gain_span)
        else $error("left gain readback outside span");

    property p_readback_ro;
        (wr_byte && acrb_hit(aw_addr_q, IDX_LEFT_GAIN)) |=>
            (left_gain_q == $past(left_clamped)) && bvalid_q;
    endproperty
    a_readback_ro: assert property (p_readback_ro)
        else $error("write disturbed left gain readback");

    property p_enable_write;
        (wr_byte && acrb_hit(aw_addr_q, IDX_EN_TGT)) |=>
            (cfg_q.enable == $past(w_byte_q[EN_BIT])) && bvalid_q && (bresp_q == RESP_OKAY);
    endproperty
    a_enable_write: assert property (p_enable_write)
        else $error("enable bit not written");

    property p_target_read;
        (ar_take && acrb_hit(s_axi_araddr, IDX_EN_TGT)) |=>
            rvalid_q && (rdata_q[TGT_LSB +: 3] == $past(cfg_q.target))
            && (rdata_q[EN_BIT] == $past(cfg_q.enable));
    endproperty
    a_target_read: assert property (p_target_read)
        else $error("target level readback wrong");

    property p_gain_hyst;
        (wr_byte && acrb_hit(aw_addr_q, IDX_EN_TGT)) |=>
            cfg_q.gain_hyst == $past(w_byte_q[GHYST_LSB +: 2]);
    endproperty
    a_gain_hyst: assert property (p_gain_hyst)
        else $error("gain hysteresis not written");

    property p_level_hyst;
        (wr_byte && acrb_hit(aw_addr_q, IDX_HYST_NOISE)) |=>
            (cfg_q.level_hyst == $past(w_byte_q[LHYST_LSB +: 2])) ##1
            (cfg_q.level_hyst == $past(w_byte_q[LHYST_LSB +: 2], 2)) || $past(wr_byte);
    endproperty
    a_level_hyst: assert property (p_level_hyst)
        else $error("level hysteresis not held");

    property p_noise_gate;
        (cfg_q.enable && (cfg_q.noise_thr != 5'h00)) |=> noise_on_q;
    endproperty
    a_noise_gate: assert property (p_noise_gate)
        else $error("noise gate not on");

    property p_noise_off;
        (cfg_q.noise_thr == 5'h00) |=> !noise_on_q;
    endproperty
    a_noise_off: assert property (p_noise_off)
        else $error("noise gate on with zero threshold");

    property p_max_sat;
        (cfg_q.enable && (cfg_q.max_gain >= MAXG_LIMIT)) |-> (right_hi == GAIN_MAX);
    endproperty
    a_max_sat: assert property (p_max_sat)
        else $error("maximum gain not saturated");

    property p_reserved_zero;
        rvalid_q |-> (rdata_q[DATA_W-1:8] == 24'h000000);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("upper read bits not zero");

    property p_gain_ceiling;
        cfg_q.enable |=> $signed(right_gain_q) <= $signed($past(right_hi));
    endproperty
    a_gain_ceiling: assert property (p_gain_ceiling)
        else $error("applied gain above maximum");

    // Raw code is kept; saturation happens only where the ceiling is used
    property p_max_store;
        (wr_byte && acrb_hit(aw_addr_q, IDX_MAX_GAIN)) |=>
            cfg_q.max_gain == $past(w_byte_q[MAXG_LSB +: 7]);
    endproperty
    a_max_store: assert property (p_max_store)
        else $error("maximum gain code not stored");

    c_enable_on:  cover property (wr_byte && acrb_hit(aw_addr_q, IDX_EN_TGT) && w_byte_q[EN_BIT]);
    c_read_gain:  cover property (ar_take && acrb_hit(s_axi_araddr, IDX_LEFT_GAIN));
    c_clamped:    cover property (cfg_q.enable && ($signed(right_gain_req) > $signed(right_hi)));
    c_bad_addr:   cover property (wr_go && !acrb_mapped(aw_addr_q));
    c_max_sat:    cover property (cfg_q.enable && (cfg_q.max_gain > MAXG_LIMIT));

endmodule // acrb_regbank

// file: core/acrb_pkg.sv
// Shared constants and types for the gain-control register bank.
// Assumes AXI4-Lite with 32-bit data and one word per register.
package acrb_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_LEFT_GAIN  = 10'h05d;
    localparam logic [9:0] IDX_EN_TGT     = 10'h05e;
    localparam logic [9:0] IDX_HYST_NOISE = 10'h05f;
    localparam logic [9:0] IDX_MAX_GAIN   = 10'h060;

    localparam logic [7:0] RST_LEFT_GAIN  = 8'h00;
    localparam logic [7:0] RST_EN_TGT     = 8'h00;
    localparam logic [7:0] RST_HYST_NOISE = 8'h00;
    localparam logic [7:0] RST_MAX_GAIN   = 8'h7f;

    // Field positions
    localparam int EN_BIT     = 7;
    localparam int TGT_LSB    = 4;
    localparam int GHYST_LSB  = 0;
    localparam int LHYST_LSB  = 6;
    localparam int NOISE_LSB  = 1;
    localparam int MAXG_LSB   = 0;

    // Gain limits in signed half-dB steps
    localparam logic [7:0] GAIN_MIN   = 8'he8;
    localparam logic [7:0] GAIN_MAX   = 8'h74;
    localparam logic [6:0] MAXG_LIMIT = 7'h74;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic       enable;
        logic [2:0] target;
        logic [1:0] gain_hyst;
        logic [1:0] level_hyst;
        logic [4:0] noise_thr;
        logic [6:0] max_gain;
    } acrb_cfg_t;

    localparam acrb_cfg_t CFG_RESET = '{
        enable:     RST_EN_TGT[EN_BIT],
        target:     RST_EN_TGT[TGT_LSB +: 3],
        gain_hyst:  RST_EN_TGT[GHYST_LSB +: 2],
        level_hyst: RST_HYST_NOISE[LHYST_LSB +: 2],
        noise_thr:  RST_HYST_NOISE[NOISE_LSB +: 5],
        max_gain:   RST_MAX_GAIN[MAXG_LSB +: 7]
    };

    function automatic logic acrb_hit(input logic [ADDR_W-1:0] a, input logic [9:0] idx);
        return (a[1:0] == 2'h0) && (a[ADDR_W-1:2] == idx);
    endfunction

    function automatic logic acrb_mapped(input logic [ADDR_W-1:0] a);
        return acrb_hit(a, IDX_LEFT_GAIN) || acrb_hit(a, IDX_EN_TGT) ||
               acrb_hit(a, IDX_HYST_NOISE) || acrb_hit(a, IDX_MAX_GAIN);
    endfunction

    // Codes above the limit act as the limit
    function automatic logic [6:0] acrb_max_eff(input logic [6:0] code);
        return (code >= MAXG_LIMIT) ? MAXG_LIMIT : code;
    endfunction

endpackage

// file: core/acrb_gain_limit.sv
// Signed gain clamp between a lower and an upper bound.
// Assumes lo is not above hi; purely combinational.
`timescale 1ns/10ps
module acrb_gain_limit
    import acrb_pkg::*;
(
    input  logic [7:0] req,
    input  logic [7:0] lo,
    input  logic [7:0] hi,
    output logic [7:0] gain
);

    always_comb begin
        if ($signed(req) > $signed(hi)) begin
            gain = hi;
        end else if ($signed(req) < $signed(lo)) begin
            gain = lo;
        end else begin
            gain = req;
        end
    end

endmodule // acrb_gain_limit

// file: tb/tb_top.sv
// Self-checking bench for the gain-control register bank over AXI4-Lite.
// Assumes the bank answers in its own time; every wait is bounded.
`timescale 1ns/10ps
module tb_top
    import acrb_pkg::*;
;
    typedef struct packed {
        logic [1:0]  resp;
        logic [31:0] data;
        logic        rd;
    } acrb_tb_exp_t;

    logic              aclk;
    logic              aresetn;
    logic [ADDR_W-1:0] awaddr;
    logic              awvalid;
    logic              awready;
    logic [DATA_W-1:0] wdata;
    logic [3:0]        wstrb;
    logic              wvalid;
    logic              wready;
    logic [1:0]        bresp;
    logic              bvalid;
    logic              bready;
    logic [ADDR_W-1:0] araddr;
    logic              arvalid;
    logic              arready;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
    logic              rvalid;
    logic              rready;
    logic [7:0]        left_gain_in;
    logic [7:0]        right_gain_req;
    acrb_cfg_t         right_cfg;
    logic [7:0]        right_gain_applied;
    logic              right_noise_gate_on;
    acrb_tb_exp_t      exq[$];
    int                fails;
    int                cmp_count;
    int                seed;
    int                i;
    int                k;
    logic [31:0]       d;
    logic [7:0]        m;
    logic [7:0]        v;

    acrb_regbank u_acrb_regbank (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .left_gain_in(left_gain_in), .right_gain_req(right_gain_req),
        .right_cfg(right_cfg), .right_gain_applied(right_gain_applied),
        .right_noise_gate_on(right_noise_gate_on)
    );

    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic test_done;
        if (fails == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    function automatic logic [11:0] ba(input logic [9:0] idx);
        return {idx, 2'b00};
    endfunction

    // Signed clamp, kept local so expectations stay independent
    function automatic logic [7:0] clampf(input logic [7:0] x, input logic [7:0] lo,
                                          input logic [7:0] hi);
        if ($signed(x) < $signed(lo)) return lo;
        if ($signed(x) > $signed(hi)) return hi;
        return x;
    endfunction

    // Response monitor: oldest note is matched to each handshake
    always @(posedge aclk) begin
        acrb_tb_exp_t e;
        if (aresetn && ((bvalid && bready) || (rvalid && rready))) begin
            if (exq.size() == 0) begin
                chk("unexpected response", 32'h1, 32'h0);
            end else begin
                e = exq.pop_front();
                chk("resp", 32'(rvalid && rready ? rresp : bresp), 32'(e.resp));
                if (e.rd) chk("rdata", rdata, e.data);
            end
        end
    end

    task automatic wr(input logic [11:0] a, input logic [31:0] dv, input logic [3:0] s,
                      input logic [1:0] r);
        int n;
        exq.push_back('{resp: r, data: 32'h0, rd: 1'b0});
        @(posedge aclk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= dv;
        wstrb   <= s;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 50) begin
            fails++;
            test_done();
        end
        bready <= 1'b0;
        // Gate flag trails the stored config by one cycle
        @(posedge aclk);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] dv, input logic [1:0] r);
        int n;
        exq.push_back('{resp: r, data: dv, rd: 1'b1});
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (n == 50) begin
            fails++;
            test_done();
        end
        rready <= 1'b0;
    endtask

    task automatic gchk(input logic [7:0] req, input logic [7:0] exp);
        @(posedge aclk);
        right_gain_req <= req;
        repeat (2) @(posedge aclk);
        chk("gain_applied", 32'(right_gain_applied), 32'(exp));
    endtask

    initial begin
        seed = 78;
        fails = 0;
        cmp_count = 0;
        aresetn = 1'b0;
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
        left_gain_in = 8'h00;
        right_gain_req = 8'h00;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        chk("cfg_reset", 32'(right_cfg), 32'h0000007f);
        rd(ba(IDX_LEFT_GAIN), 32'h00, RESP_OKAY);
        rd(ba(IDX_EN_TGT), 32'h00, RESP_OKAY);
        rd(ba(IDX_HYST_NOISE), 32'h00, RESP_OKAY);
        rd(ba(IDX_MAX_GAIN), 32'h7f, RESP_OKAY);
        // Every target code, every gain hysteresis code, reserved bits 3..2 held at zero
        for (i = 0; i < 8; i++) begin
            d = $random(seed);
            d[7] = i[0];
            d[6:4] = i[2:0];
            d[1:0] = i[1:0];
            d[3:2] = 2'b00;
            wr(ba(IDX_EN_TGT), d, 4'h1, RESP_OKAY);
            rd(ba(IDX_EN_TGT), {24'h0, d[7:0] & 8'hf3}, RESP_OKAY);
            chk("enable", 32'(right_cfg.enable), 32'(i[0]));
            chk("target", 32'(right_cfg.target), 32'(i[2:0]));
            chk("gain_hyst", 32'(right_cfg.gain_hyst), 32'(i[1:0]));
        end
        // Level hysteresis codes with noise boundaries; enable stays set from the last target write
        for (i = 0; i < 4; i++) begin
            d = $random(seed);
            d[7:6] = i[1:0];
            if (i < 3) d[5:1] = (i == 0) ? 5'h00 : (i == 1) ? 5'h01 : 5'h1f;
            d[0] = 1'b0;
            wr(ba(IDX_HYST_NOISE), d, 4'h1, RESP_OKAY);
            rd(ba(IDX_HYST_NOISE), {24'h0, d[7:0] & 8'hfe}, RESP_OKAY);
            chk("level_hyst", 32'(right_cfg.level_hyst), 32'(i[1:0]));
            chk("noise_thr", 32'(right_cfg.noise_thr), 32'(d[5:1]));
            chk("gate", 32'(right_noise_gate_on), 32'(d[5:1] != 5'h0));
        end
        // Ceiling codes including the saturating ones
        for (i = 0; i < 4; i++) begin
            // Top bit stays zero, the host keeps the reserved bit clear
            m = (i == 0) ? 8'h00 : (i == 1) ? 8'h74 : (i == 2) ? 8'h75 : 8'h7f;
            wr(ba(IDX_MAX_GAIN), {24'h0, m}, 4'h1, RESP_OKAY);
            rd(ba(IDX_MAX_GAIN), {24'h0, m & 8'h7f}, RESP_OKAY);
            for (k = 0; k < 4; k++) begin
                v = (k == 0) ? 8'h7f : (k == 1) ? 8'h80 : 8'($random(seed));
                gchk(v, clampf(v, 8'he8, (m > 8'h74) ? 8'h74 : m));
            end
        end
        // Disabled: no ceiling beyond the documented span, gate off
        wr(ba(IDX_EN_TGT), 32'h00, 4'h1, RESP_OKAY);
        chk("gate_off", 32'(right_noise_gate_on), 32'h0);
        gchk(8'h7f, 8'h74);
        gchk(8'h80, 8'he8);
        // Strobe off: no store
        wr(ba(IDX_MAX_GAIN), 32'h11, 4'h0, RESP_OKAY);
        rd(ba(IDX_MAX_GAIN), 32'h7f, RESP_OKAY);
        // Left readback follows applied gain within -12..+58 dB
        for (i = 0; i < 8; i++) begin
            v = (i == 0) ? 8'he8 : (i == 1) ? 8'h74 : (i == 2) ? 8'he7 :
                (i == 3) ? 8'h75 : (i == 4) ? 8'h00 : 8'($random(seed));
            @(posedge aclk);
            left_gain_in <= v;
            repeat (2) @(posedge aclk);
            rd(ba(IDX_LEFT_GAIN), {24'h0, clampf(v, 8'he8, 8'h74)}, RESP_OKAY);
        end
        // Read-only readback, unmapped and unaligned places
        wr(ba(IDX_LEFT_GAIN), 32'hff, 4'h1, RESP_OKAY);
        rd(ba(IDX_LEFT_GAIN), {24'h0, clampf(v, 8'he8, 8'h74)}, RESP_OKAY);
        wr(12'h184, 32'h55, 4'h1, RESP_SLVERR);
        rd(12'h175, 32'h0, RESP_SLVERR);
        rd(12'h000, 32'h0, RESP_SLVERR);
        repeat (4) @(posedge aclk);
        chk("pending_notes", 32'(exq.size()), 32'h0);
        test_done();
    end
endmodule // tb_top
